// ---- hw/anps_pkg.sv ----
package anps_pkg;

    // ***************************************************
    // register indices, byte address is four times these
    // ***************************************************
    localparam logic [5:0] IDX_NEXT_PAGE  = 6'h05;
    localparam logic [5:0] IDX_EXPANSION  = 6'h06;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h08;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h09;

    // ***************************************************
    // field positions
    // ***************************************************
    localparam int NP_REQ_BIT   = 15;
    localparam int ACK_BIT      = 14;
    localparam int MSG_PAGE_BIT = 13;
    localparam int COMPLY_BIT   = 12;
    localparam int TOGGLE_BIT   = 11;
    localparam int CODE_MSB     = 10;
    localparam int PDF_BIT      = 4;
    localparam int LP_NP_BIT    = 3;
    localparam int LOC_NP_BIT   = 2;
    localparam int PAGE_RX_BIT  = 1;
    localparam int LP_AN_BIT    = 0;
    localparam int IRQ_PAGE_BIT = 0;
    localparam int IRQ_PDF_BIT  = 1;

    // ***************************************************
    // reset values
    // ***************************************************
    localparam logic [15:0] NEXT_PAGE_RST = 16'h0000;
    localparam logic        LOCAL_NP_RST  = 1'b1;
    localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
    localparam logic [1:0]  IRQ_STAT_RST  = 2'h0;

endpackage : anps_pkg

// ---- hw/anps_wb_slave.sv ----
`timescale 1ns/1ps
// ***************************************************
// classic wishbone handshake
// ***************************************************
module anps_wb_slave
(
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    input  wire logic wb_cyc_i,
    input  wire logic wb_stb_i,
    output logic      wb_ack_o,
    output logic      req_o
);
    import anps_pkg::*;

    typedef struct packed {
        logic ack;
    } anps_wbs_st_t;

    anps_wbs_st_t st_ff;
    anps_wbs_st_t nxt_st;

    // one access per request; ack drops the cycle after it rose
    always_comb
    begin
        nxt_st     = st_ff;
        nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign wb_ack_o = st_ff.ack;
    // request is taken only in the cycle before ack rises
    assign req_o    = wb_cyc_i & wb_stb_i & ~st_ff.ack;

    chk_ack_single_pulse: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        st_ff.ack |=> !st_ff.ack)
        else $error("ack held longer than one cycle");

endmodule : anps_wb_slave

// ---- hw/anps_page_capture.sv ----
`timescale 1ns/1ps
// ***************************************************
// atomic capture of received link code words
// ***************************************************
module anps_page_capture
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        page_strobe_i,
    input  wire logic        page_is_next_i,
    input  wire logic [15:0] page_word_i,
    output logic      [15:0] np_word_o,
    output logic             partner_next_page_capable_o
);
    import anps_pkg::*;

    typedef struct packed {
        logic [15:0] np_word;
        logic        lp_np;
    } anps_cap_st_t;

    anps_cap_st_t st_ff;
    anps_cap_st_t nxt_st;

    // whole word loads in one edge so a read never sees a mix
    always_comb
    begin
        nxt_st = st_ff;
        if (page_strobe_i && page_is_next_i)
            nxt_st.np_word = page_word_i;
        // partner next-page ability comes from the base page
        if (page_strobe_i && !page_is_next_i)
            nxt_st.lp_np = page_word_i[NP_REQ_BIT];
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff.np_word <= NEXT_PAGE_RST;
            st_ff.lp_np   <= 1'b0;
        end
        else
            st_ff <= nxt_st;
    end

    assign np_word_o                   = st_ff.np_word;
    assign partner_next_page_capable_o = st_ff.lp_np;

    chk_np_word_load: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        page_strobe_i && page_is_next_i
        |=> st_ff.np_word == $past(page_word_i))
        else $error("next page word not captured whole");

    chk_ack_from_word: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        page_strobe_i && page_is_next_i
        |=> st_ff.np_word[ACK_BIT] == $past(page_word_i[ACK_BIT]))
        else $error("partner acknowledge not taken from word");

    chk_np_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !(page_strobe_i && page_is_next_i) |=> $stable(st_ff.np_word))
        else $error("next page word changed without a page");

    chk_lp_np_base: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        page_strobe_i && !page_is_next_i
        |=> st_ff.lp_np == $past(page_word_i[NP_REQ_BIT]))
        else $error("partner next page ability wrong");

endmodule : anps_page_capture

// ---- hw/anps_top.sv ----
`timescale 1ns/1ps
// ***************************************************
// auto-negotiation next page and expansion status
// ***************************************************
module anps_top
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // arbitration side
    input  wire logic        page_strobe_i,
    input  wire logic        page_is_next_i,
    input  wire logic [15:0] page_word_i,
    input  wire logic        par_fault_i,
    input  wire logic        partner_an_capable_i,
    input  wire logic        local_np_strap_i,
    output logic             irq_o
);
    import anps_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic [31:0] dat;
        logic        parallel_detect_fault;
        logic        lp_an;
        logic        local_np;
        logic        strap_done;
        logic        page_rx;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
    } anps_top_st_t;

    anps_top_st_t st_ff;
    anps_top_st_t nxt_st;

    logic        req;
    logic [5:0]  idx;
    logic        rd_exp;
    logic        wr_lane0;
    logic [15:0] np_word;
    logic        lp_np;
    logic [15:0] exp_val;
    logic [1:0]  irq_ev;
    logic [31:0] rd_val;

    // ***************************************************
    // submodules
    // ***************************************************
    anps_wb_slave u_wbs
    (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_ack_o  (wb_ack_o),
        .req_o     (req)
    );

    anps_page_capture u_cap
    (
        .sys_clk_i                   (sys_clk_i),
        .rstn_i                      (rstn_i),
        .page_strobe_i               (page_strobe_i),
        .page_is_next_i              (page_is_next_i),
        .page_word_i                 (page_word_i),
        .np_word_o                   (np_word),
        .partner_next_page_capable_o (lp_np)
    );

    // ***************************************************
    // decode
    // ***************************************************
    // low two address bits ignored, every register is a word
    assign idx      = wb_adr_i[7:2];
    assign rd_exp   = req & ~wb_we_i & (idx == IDX_EXPANSION);
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

    // expansion view, reserved upper bits tied low
    always_comb
    begin
        exp_val              = 16'h0000;
        exp_val[PDF_BIT]     = st_ff.parallel_detect_fault;
        exp_val[LP_NP_BIT]   = lp_np;
        exp_val[LOC_NP_BIT]  = st_ff.local_np;
        exp_val[PAGE_RX_BIT] = st_ff.page_rx;
        exp_val[LP_AN_BIT]   = st_ff.lp_an;
    end

    // read mux; unmapped words read zero and still ack
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (idx)
            IDX_NEXT_PAGE:  rd_val[15:0] = np_word;
            IDX_EXPANSION:  rd_val[15:0] = exp_val;
            IDX_IRQ_STATUS: rd_val[1:0]  = st_ff.irq_stat;
            IDX_IRQ_MASK:   rd_val[1:0]  = st_ff.irq_mask;
            default:        rd_val       = 32'h0000_0000;
        endcase
    end

    // interrupt events: page arrival and fault onset
    assign irq_ev[IRQ_PAGE_BIT] = page_strobe_i;
    assign irq_ev[IRQ_PDF_BIT]  = par_fault_i & ~st_ff.parallel_detect_fault;

    // ***************************************************
    // next state
    // ***************************************************
    always_comb
    begin
        nxt_st = st_ff;
        // level status follows arbitration outputs
        nxt_st.parallel_detect_fault   = par_fault_i;
        nxt_st.lp_an = partner_an_capable_i;
        // strap sampled once, first clock after reset release
        if (!st_ff.strap_done)
        begin
            nxt_st.local_np   = local_np_strap_i;
            nxt_st.strap_done = 1'b1;
        end
        // arrival beats the clear-on-read in the same cycle
        if (page_strobe_i)
            nxt_st.page_rx = 1'b1;
        else if (rd_exp)
            nxt_st.page_rx = 1'b0;
        // status write-one-to-clear, a new event wins
        if (wr_lane0 && idx == IDX_IRQ_STATUS)
            nxt_st.irq_stat = st_ff.irq_stat & ~wb_dat_i[1:0];
        nxt_st.irq_stat = nxt_st.irq_stat | irq_ev;
        if (wr_lane0 && idx == IDX_IRQ_MASK)
            nxt_st.irq_mask = wb_dat_i[1:0];
        // read data captured on the request cycle with ack
        if (req && !wb_we_i)
            nxt_st.dat = rd_val;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    // ***************************************************
    // registers
    // ***************************************************
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff            <= '0;
            st_ff.local_np   <= LOCAL_NP_RST;
            st_ff.irq_mask   <= IRQ_MASK_RST;
            st_ff.irq_stat   <= IRQ_STAT_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign wb_dat_o = st_ff.dat;
    assign irq_o    = st_ff.irq;

    // ***************************************************
    // checks
    // ***************************************************
    chk_page_rx_set: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        page_strobe_i |=> st_ff.page_rx)
        else $error("page received flag not set");

    chk_page_rx_cor: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        rd_exp && !page_strobe_i |=> !st_ff.page_rx)
        else $error("page received flag not cleared by read");

    chk_set_beats_clear: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        rd_exp && page_strobe_i |=> st_ff.page_rx)
        else $error("arrival lost against clear on read");

    chk_exp_reserved: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        rd_exp |=> wb_ack_o && wb_dat_o[31:5] == 27'h0)
        else $error("expansion reserved bits not zero");

    chk_pdf_follow: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        rd_exp ##0 st_ff.parallel_detect_fault |=> wb_dat_o[PDF_BIT])
        else $error("fault bit not reported");

    chk_lp_an_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        rd_exp |=> wb_dat_o[LP_AN_BIT] == $past(st_ff.lp_an)
            && st_ff.lp_an == $past(partner_an_capable_i))
        else $error("partner autoneg ability wrong");

    chk_local_np_rst: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !st_ff.strap_done |-> st_ff.local_np
            ##1 st_ff.local_np == $past(local_np_strap_i)
            ##1 $stable(st_ff.local_np))
        else $error("local next page ability wrong after reset");

    chk_np_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        req && !wb_we_i && idx == IDX_NEXT_PAGE
        |=> wb_ack_o && wb_dat_o[15:0] == $past(np_word)
            && wb_dat_o[31:16] == 16'h0000)
        else $error("next page word read wrong");

    chk_irq_stat_set: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        page_strobe_i |=> st_ff.irq_stat[IRQ_PAGE_BIT]
            && (irq_o == |(st_ff.irq_stat & st_ff.irq_mask)))
        else $error("interrupt status or level wrong");

    // ***************************************************
    // checks: bus handshake
    // ***************************************************
    // ack is the registered request, so it never runs ahead of cyc
    chk_ack_after_req: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        req
        |=> wb_ack_o)
        else $error("request not acknowledged");

    chk_ack_needs_req: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !req
        |=> !wb_ack_o)
        else $error("ack given without a request");

    chk_dat_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !(req && !wb_we_i)
        |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    chk_unmapped_zero: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        req && !wb_we_i && idx != IDX_NEXT_PAGE && idx != IDX_EXPANSION
            && idx != IDX_IRQ_STATUS && idx != IDX_IRQ_MASK
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped word did not read zero");

    // ***************************************************
    // checks: status levels
    // ***************************************************
    // levels lag their inputs by one edge, never more
    chk_pdf_level: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        1'b1
        |=> st_ff.parallel_detect_fault == $past(par_fault_i))
        else $error("fault bit does not follow its input");

    chk_lp_an_level: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        1'b1
        |=> st_ff.lp_an == $past(partner_an_capable_i))
        else $error("partner autoneg bit does not follow input");

    chk_lp_np_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        rd_exp
        |=> wb_dat_o[LP_NP_BIT] == $past(lp_np))
        else $error("partner next page ability read wrong");

    chk_page_rx_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !page_strobe_i && !rd_exp
        |=> $stable(st_ff.page_rx))
        else $error("page received flag changed on its own");

    chk_local_np_keep: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        st_ff.strap_done
        |=> $stable(st_ff.local_np))
        else $error("local next page ability changed after strap");

    // ***************************************************
    // checks: interrupts
    // ***************************************************
    // a fault that stays high raises one event, not one per cycle
    chk_fault_onset: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        par_fault_i && !st_ff.parallel_detect_fault
        |=> st_ff.irq_stat[IRQ_PDF_BIT])
        else $error("fault onset did not set status");

    chk_mask_write: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        wr_lane0 && idx == IDX_IRQ_MASK
        |=> st_ff.irq_mask == $past(wb_dat_i[1:0]))
        else $error("interrupt mask not written");

    chk_w1c_clear: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        wr_lane0 && idx == IDX_IRQ_STATUS
        |=> (st_ff.irq_stat & $past(wb_dat_i[1:0] & ~irq_ev)) == 2'h0)
        else $error("interrupt status not cleared by write");

endmodule : anps_top

// ---- tb/anps_partner.sv ----
`timescale 1ns/1ps
// ********
// remote link partner handing over link code words
// ********
module anps_partner
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        send_i,
    input  wire logic        kind_i,
    input  wire logic [15:0] word_i,
    output logic             page_strobe_o,
    output logic             page_is_next_o,
    output logic      [15:0] page_word_o
);
    // strobe is send_i one edge late; lines flip outside it so stale data never passes
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            page_strobe_o  <= 1'b0;
            page_is_next_o <= 1'b0;
            page_word_o    <= 16'hA5A5;
        end
        else
        begin
            page_strobe_o  <= send_i;
            page_is_next_o <= send_i ? kind_i : ~page_is_next_o;
            page_word_o    <= send_i ? word_i : ~page_word_o;
        end
    end
endmodule : anps_partner

// ---- tb/anps_tb_top.sv ----
`timescale 1ns/1ps
module anps_tb_top;
    import anps_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn, cyc, stb, we, send, kind, flt, an, strap;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic        ack, irq, pstb, pnext;
    logic [15:0] word, pword, w;
    int          err_count, comparisons, seed, i;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    anps_top dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .page_strobe_i(pstb), .page_is_next_i(pnext),
        .page_word_i(pword), .par_fault_i(flt),
        .partner_an_capable_i(an), .local_np_strap_i(strap), .irq_o(irq));

    anps_partner partner (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .send_i(send), .kind_i(kind), .word_i(word),
        .page_strobe_o(pstb), .page_is_next_o(pnext),
        .page_word_o(pword));

    // ********
    // helpers
    // ********
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle; caller sits just after an edge
    task automatic wb(input logic w_i, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w_i;
        adr  <= a;
        wdat <= d;
        sel  <= 4'h1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        r = rdat;
        if (n >= 20)
        begin
            err_count++;
            give_verdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        wb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd

    // page arrives one edge on; two more edges let its update land
    task automatic send_page(input logic k, input logic [15:0] v);
        send <= 1'b1;
        kind <= k;
        word <= v;
        @(posedge sys_clk);
        send <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : send_page

    function automatic logic [31:0] xs(input int f, pc, lc, rx, a);
        return {27'h0, f[0], pc[0], lc[0], rx[0], a[0]};
    endfunction : xs

    // ********
    // main sequence
    // ********
    initial
    begin
        {cyc, stb, we, send, kind, flt, an} = 7'h00;
        {adr, sel, wdat, word} = 60'h0;
        strap = 1'b1;
        seed = 41;
        rstn = 1'b0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'h14, 32'h0, "page reset");
        rd(8'h18, xs(0, 0, 1, 0, 0), "expansion reset");
        wb(1'b1, 8'h18, 32'hFFFFFFFF, q);
        wb(1'b1, 8'h14, 32'hFFFFFFFF, q);
        rd(8'h18, xs(0, 0, 1, 0, 0), "expansion write");
        rd(8'h14, 32'h0, "page write");
        rd(8'h3C, 32'h0, "unmapped");
        $display("test reset and writes done");
        // level inputs: fault onset is masked so irq stays low
        flt <= 1'b1;
        an  <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(8'h18, xs(1, 0, 1, 0, 1), "fault high");
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(8'h20, 32'h2, "irq status");
        wb(1'b1, 8'h24, 32'h2, q);
        chk("irq fault", 32'h1, {31'h0, irq});
        wb(1'b1, 8'h20, 32'h2, q);
        chk("irq clear", 32'h0, {31'h0, irq});
        flt <= 1'b0;
        @(posedge sys_clk);
        rd(8'h18, xs(0, 0, 1, 0, 1), "fault low");
        $display("test fault done");
        // random next pages, all-ones and all-zeros first
        wb(1'b1, 8'h24, 32'h1, q);
        for (i = 0; i < 8; i++)
        begin
            w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0 : 16'($random(seed));
            send_page(1'b1, w);
            chk("irq page", 32'h1, {31'h0, irq});
            rd(8'h14, {16'h0, w}, "page word");
            rd(8'h18, xs(0, 0, 1, 1, 1), "page rx set");
            rd(8'h18, xs(0, 0, 1, 0, 1), "page rx clear");
            wb(1'b1, 8'h20, 32'h1, q);
            chk("irq w1c", 32'h0, {31'h0, irq});
        end
        // base pages carry partner capability, leave next page word
        send_page(1'b0, 16'h8000);
        rd(8'h18, xs(0, 1, 1, 1, 1), "capable");
        rd(8'h14, {16'h0, w}, "page kept");
        send_page(1'b0, 16'h7FFF);
        rd(8'h18, xs(0, 0, 1, 1, 1), "not capable");
        $display("test pages done");
        // page lands on the very edge that clears by read
        send <= 1'b1;
        kind <= 1'b1;
        word <= 16'h1234;
        @(posedge sys_clk);
        send <= 1'b0;
        wb(1'b0, 8'h18, 32'h0, q);
        rd(8'h18, xs(0, 0, 1, 1, 1), "set wins");
        rd(8'h14, 32'h1234, "late word");
        $display("test collision done");
        // second reset with strap low
        rstn  <= 1'b0;
        strap <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'h18, xs(0, 0, 0, 0, 1), "strap low");
        rd(8'h14, 32'h0, "page rereset");
        $display("test strap done");
        give_verdict();
    end
endmodule : anps_tb_top
